/* File: core/cspc_top.sv */
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
// Functional notes
// - port stays idle, no send or receive, unless port_enable is set
// - rs232 mode: transmit and receive run at the same time
// - rs485 mode: driver on only while sending, receiver listens otherwise
// - bit timing from bit_rate_select, 9600 to 115200; far end matches
// - every character is start, eight data bits, no parity, one stop
// - edge_rate_select fast applied only in rs485 mode
// - protocol_select picks ascii, modbus or binary handling of commands
// - ascii strings end at a zero byte, both directions
// - text_send_cmd sends text_tx_buffer over the link
// - text_fetch_cmd moves up to text_rx_count bytes into text_rx_buffer
// - modbus client only: issue request, await reply; codes 03 and 06
// - modbus commands accepted only in rs485 mode
// - each request carries server_id and holding_reg_addr
// - reg_write_cmd sends function 06 with reg_write_value; server replies
// - reg_read_cmd sends function 03; reply value shown in reg_read_result
// - raw_send_cmd sends exactly raw_tx_count bytes unaltered
// - raw_fetch_cmd places raw_rx_count received bytes in raw_rx_buffer; here fetch stops early once the queue is empty
module cspc_top #(
  parameter int          DEPTH       = 16,
  parameter int          RXQ_DEPTH   = 16,
  parameter int unsigned RESP_TO_CYC = cspc_pkg::RESP_TO_CYC_DFLT
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // register port
  input  wire logic [cspc_pkg::AW-1:0] reg_addr,
  input  wire logic [cspc_pkg::DW-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [cspc_pkg::DW-1:0] reg_rdata,
  // transceiver pins
  input  wire logic                   ser_rxd,
  output logic                        ser_txd,
  output logic                        ser_drv_en,
  output logic                        ser_rcv_en_n,
  output logic                        ser_rs485_sel,
  output logic                        ser_edge_fast
);
  import cspc_pkg::*;
  localparam int IW = $clog2(DEPTH);
  localparam int QW = $clog2(RXQ_DEPTH);
  localparam int CW = (IW + 1 > 4) ? IW + 1 : 4;

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [7:0]  server_id_q;
  logic [15:0] holding_reg_addr_q;
  logic [15:0] reg_write_value_q;
  logic [15:0] reg_read_result_q;
  logic [IW:0] raw_tx_count_q;
  logic [IW:0] text_rx_count_q;
  logic [IW:0] raw_rx_count_q;
  logic [7:0]  text_tx_buffer_q [DEPTH];
  logic [7:0]  rx_out_q [DEPTH];
  logic [IW-1:0] bidx;
  logic [6:0]  cmd;
  logic        port_enable;
  logic        mode485;
  cspc_prot_t  prot;
  logic [15:0] div;
  logic [31:0] gap_cyc;
  assign port_enable = ctrl_q[CTL_EN];
  assign mode485     = ctrl_q[CTL_MODE];
  assign prot        = cspc_prot_t'(ctrl_q[CTL_PROT+:2]);
  assign div         = cspc_div(ctrl_q[CTL_BAUD+:3]);
  assign gap_cyc     = GAP_BITS * {16'h0000, div};
  assign bidx        = reg_addr[IW+1:2];
  assign cmd = (reg_wr && reg_addr == OFS_CMD) ? reg_wdata[6:0] : 7'h00;

  // software writes to configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q             <= CTRL_RST;
      server_id_q        <= '0;
      holding_reg_addr_q <= '0;
      reg_write_value_q  <= '0;
      raw_tx_count_q     <= '0;
      text_rx_count_q    <= '0;
      raw_rx_count_q     <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL:   ctrl_q             <= reg_wdata[7:0];
        OFS_SERVER: server_id_q        <= reg_wdata[7:0];
        OFS_HADDR:  holding_reg_addr_q <= reg_wdata[15:0];
        OFS_WVAL:   reg_write_value_q  <= reg_wdata[15:0];
        OFS_TXCNT:  raw_tx_count_q     <= reg_wdata[IW:0];
        OFS_TRXCNT: text_rx_count_q    <= reg_wdata[IW:0];
        OFS_RRXCNT: raw_rx_count_q     <= reg_wdata[IW:0];
        default:    ;
      endcase
    end
  end

  // transmit buffer shared by text and raw sends; plain storage, no reset
  always_ff @(posedge clk) begin
    if (reg_wr && reg_addr[7:6] == RGN_TXBUF) text_tx_buffer_q[bidx] <= reg_wdata[7:0];
  end

  // ----------------------------------------------------------------
  // two-entry buffer between sequencer and shifter
  // ----------------------------------------------------------------
  logic [7:0] fb_q [2];
  logic [1:0] fb_cnt_q;
  logic       fb_wp_q;
  logic       fb_rp_q;
  logic       in_valid;
  logic       in_ready;
  logic [7:0] in_data;
  logic       out_valid;
  logic       out_ready;
  assign in_ready  = fb_cnt_q != 2'h2;
  assign out_valid = fb_cnt_q != 2'h0;

  // a stalled shifter back-pressures the sequencer, so no byte is lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fb_cnt_q <= '0;
      fb_wp_q  <= 1'b0;
      fb_rp_q  <= 1'b0;
    end else if (!port_enable) begin
      fb_cnt_q <= '0;
      fb_wp_q  <= 1'b0;
      fb_rp_q  <= 1'b0;
    end else begin
      if (in_valid && in_ready) fb_wp_q <= ~fb_wp_q;
      if (out_valid && out_ready) fb_rp_q <= ~fb_rp_q;
      fb_cnt_q <= fb_cnt_q + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) fb_q[fb_wp_q] <= in_data;
  end

  // ----------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------
  logic [9:0]  tsh_q;
  logic [3:0]  tbit_q;
  logic [15:0] tcnt_q;
  logic        tx_busy_q;
  assign out_ready = port_enable && !tx_busy_q;
  assign ser_txd   = tsh_q[0];

  // frame is start, eight data lsb first, stop; idle line is high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tsh_q     <= '1;
      tbit_q    <= '0;
      tcnt_q    <= '0;
      tx_busy_q <= 1'b0;
    end else if (!port_enable) begin
      tsh_q     <= '1;
      tx_busy_q <= 1'b0;
    end else if (!tx_busy_q) begin
      if (out_valid) begin
        tsh_q     <= {1'b1, fb_q[fb_rp_q], 1'b0};
        tbit_q    <= '0;
        tcnt_q    <= '0;
        tx_busy_q <= 1'b1;
      end
    end else if (tcnt_q == div - 16'h0001) begin
      tcnt_q <= '0;
      tsh_q  <= {1'b1, tsh_q[9:1]};
      tbit_q <= tbit_q + 4'h1;
      if (tbit_q == 4'(DATA_BITS + 1)) tx_busy_q <= 1'b0;
    end else begin
      tcnt_q <= tcnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  logic        rxd_s1_q;
  logic        rxd_s2_q;
  logic        rxd_p_q;
  logic        rx_busy_q;
  logic [3:0]  rbit_q;
  logic [15:0] rcnt_q;
  logic [7:0]  rsh_q;
  logic        rx_vld_q;
  logic        listen;
  cspc_seq_t   seq_q;
  // half duplex: in rs485 our own echo must not be taken as input
  assign listen = port_enable && (!mode485 || (!tx_busy_q && seq_q != S_SEND
                  && seq_q != S_DRAIN));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      rxd_p_q  <= 1'b1;
    end else begin
      rxd_s1_q <= ser_rxd;
      rxd_s2_q <= rxd_s1_q;
      rxd_p_q  <= rxd_s2_q;
    end
  end

  // start found on falling edge, each bit sampled at its middle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_busy_q <= 1'b0;
      rbit_q    <= '0;
      rcnt_q    <= '0;
      rsh_q     <= '0;
      rx_vld_q  <= 1'b0;
    end else begin
      rx_vld_q <= 1'b0;
      if (!listen) begin
        rx_busy_q <= 1'b0;
      end else if (!rx_busy_q) begin
        if (rxd_p_q && !rxd_s2_q) begin
          rx_busy_q <= 1'b1;
          rbit_q    <= '0;
          rcnt_q    <= {1'b0, div[15:1]};
        end
      end else if (rcnt_q == div - 16'h0001) begin
        rcnt_q <= '0;
        rbit_q <= rbit_q + 4'h1;
        if (rbit_q == 4'h0) begin
          if (rxd_s2_q) rx_busy_q <= 1'b0;                             // false start
        end else if (rbit_q <= 4'(DATA_BITS)) begin
          rsh_q <= {rxd_s2_q, rsh_q[7:1]};
        end else begin
          rx_busy_q <= 1'b0;
          rx_vld_q  <= rxd_s2_q;
        end
      end else begin
        rcnt_q <= rcnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // input queue and fetch
  // ----------------------------------------------------------------
  logic [7:0]  rxq_q [RXQ_DEPTH];
  logic [QW-1:0] rq_wp_q;
  logic [QW-1:0] rq_rp_q;
  logic [QW:0] rq_lvl_q;
  logic        rq_push;
  logic        rq_pop;
  logic        overrun_q;
  logic        fetch_busy_q;
  logic        fetch_text_q;
  logic        fetch_zero_q;
  logic [IW:0] fetch_cnt_q;
  logic [IW:0] fetch_lim;
  logic        fetch_go;
  // modbus replies go to the parser, not into the queue
  assign rq_push  = rx_vld_q && seq_q != S_WAIT
                    && rq_lvl_q != (QW+1)'(RXQ_DEPTH);
  assign rq_pop   = fetch_busy_q && fetch_cnt_q != fetch_lim
                    && rq_lvl_q != '0 && !fetch_zero_q;
  assign fetch_lim = fetch_text_q ? text_rx_count_q : raw_rx_count_q;
  assign fetch_go = port_enable && !fetch_busy_q
                    && ((cmd[CMD_TFETCH] && prot == PROT_ASCII)
                    || (cmd[CMD_RFETCH] && prot == PROT_BINARY));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rq_wp_q  <= '0;
      rq_rp_q  <= '0;
      rq_lvl_q <= '0;
    end else begin
      if (rq_push) rq_wp_q <= rq_wp_q + QW'(1);
      if (rq_pop) rq_rp_q <= rq_rp_q + QW'(1);
      rq_lvl_q <= rq_lvl_q + (QW+1)'(rq_push) - (QW+1)'(rq_pop);
    end
  end

  always_ff @(posedge clk) begin
    if (rq_push) rxq_q[rq_wp_q] <= rsh_q;
    if (rq_pop) rx_out_q[fetch_cnt_q[IW-1:0]] <= rxq_q[rq_rp_q];
  end

  // overrun is sticky; a new drop beats a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) overrun_q <= 1'b0;
    else if (rx_vld_q && seq_q != S_WAIT && !rq_push) overrun_q <= 1'b1;
    else if (cmd[CMD_CLR]) overrun_q <= 1'b0;
  end

  // fetch stops at count, empty queue, or after a zero byte in text
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_busy_q <= 1'b0;
      fetch_text_q <= 1'b0;
      fetch_zero_q <= 1'b0;
      fetch_cnt_q  <= '0;
    end else if (fetch_go) begin
      fetch_busy_q <= 1'b1;
      fetch_text_q <= prot == PROT_ASCII;
      fetch_zero_q <= 1'b0;
      fetch_cnt_q  <= '0;
    end else if (rq_pop) begin
      fetch_cnt_q  <= fetch_cnt_q + (IW+1)'(1);
      fetch_zero_q <= fetch_text_q && rxq_q[rq_rp_q] == 8'h00;
    end else begin
      fetch_busy_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // send sequencer and modbus client
  // ----------------------------------------------------------------
  cspc_kind_t  kind_q;
  logic [CW-1:0] idx_q;
  logic [15:0] crc_q;
  logic [15:0] rcrc_q;
  logic [31:0] tmr_q;
  logic [3:0]  rnum_q;
  logic [7:0]  mrx_q [5];
  logic        mb_ok_q;
  logic        mb_err_q;
  logic        send_go;
  logic        mb_go;
  logic        src_end;
  logic [7:0]  mb_byte;
  logic        mb_good;
  logic [3:0]  mb_rlen;
  assign mb_go   = port_enable && mode485 && prot == PROT_MODBUS
                   && (cmd[CMD_MBWR] || cmd[CMD_MBRD]);
  assign send_go = seq_q == S_IDLE && (mb_go || (port_enable
                   && ((cmd[CMD_TSEND] && prot == PROT_ASCII)
                   || (cmd[CMD_RSEND] && prot == PROT_BINARY))));
  assign mb_rlen = kind_q == K_MBRD ? 4'(MB_RD_RLEN) : 4'(MB_WR_RLEN);
  assign mb_good = rcrc_q == 16'h0000 && rnum_q == mb_rlen && mrx_q[0] == server_id_q
                   && mrx_q[1] == (kind_q == K_MBRD ? FC_RD : FC_WR);

  // byte source for each kind of send
  always_comb begin
    case (idx_q[2:0])
      3'h0:    mb_byte = server_id_q;
      3'h1:    mb_byte = kind_q == K_MBRD ? FC_RD : FC_WR;
      3'h2:    mb_byte = holding_reg_addr_q[15:8];
      3'h3:    mb_byte = holding_reg_addr_q[7:0];
      3'h4:    mb_byte = kind_q == K_MBRD ? MB_RD_QTY[15:8] : reg_write_value_q[15:8];
      3'h5:    mb_byte = kind_q == K_MBRD ? MB_RD_QTY[7:0] : reg_write_value_q[7:0];
      3'h6:    mb_byte = crc_q[7:0];
      default: mb_byte = crc_q[15:8];
    endcase
    case (kind_q)
      K_TEXT: begin
        in_data = text_tx_buffer_q[idx_q[IW-1:0]];
        src_end = idx_q == CW'(DEPTH) || in_data == 8'h00;
      end
      K_RAW: begin
        in_data = text_tx_buffer_q[idx_q[IW-1:0]];
        src_end = idx_q == CW'(raw_tx_count_q);
      end
      default: begin
        in_data = mb_byte;
        src_end = idx_q == CW'(MB_REQ_LEN);
      end
    endcase
    in_valid = seq_q == S_SEND && !src_end;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_q    <= S_IDLE;
      kind_q   <= K_TEXT;
      idx_q    <= '0;
      crc_q    <= CRC_INIT;
      rcrc_q   <= CRC_INIT;
      tmr_q    <= '0;
      rnum_q   <= '0;
      mb_ok_q  <= 1'b0;
      mb_err_q <= 1'b0;
      reg_read_result_q <= '0;
    end else if (!port_enable) begin
      seq_q <= S_IDLE;
    end else begin
      case (seq_q)
        S_IDLE: if (send_go) begin
          idx_q  <= '0;
          crc_q  <= CRC_INIT;
          tmr_q  <= '0;
          if (mb_go) begin
            kind_q   <= cmd[CMD_MBRD] ? K_MBRD : K_MBWR;
            mb_ok_q  <= 1'b0;
            mb_err_q <= 1'b0;
            seq_q    <= S_GAP;
          end else begin
            kind_q <= prot == PROT_BINARY ? K_RAW : K_TEXT;
            seq_q  <= S_SEND;
          end
        end
        // line must be quiet 3.5 characters before a request
        S_GAP: begin
          tmr_q <= rx_busy_q ? '0 : tmr_q + 32'h0000_0001;
          if (tmr_q >= gap_cyc) seq_q <= S_SEND;
        end
        S_SEND: begin
          if (src_end) seq_q <= S_DRAIN;
          else if (in_ready) begin
            idx_q <= idx_q + CW'(1);
            if (idx_q < CW'(MB_CRC_POS)) crc_q <= cspc_crc(crc_q, in_data);
          end
        end
        S_DRAIN: if (!out_valid && !tx_busy_q) begin
          tmr_q  <= '0;
          rnum_q <= '0;
          rcrc_q <= CRC_INIT;
          seq_q  <= kind_q[1] ? S_WAIT : S_IDLE;
        end
        // reply ends on a 3.5 character gap; no reply at all times out
        S_WAIT: begin
          tmr_q <= rx_vld_q ? '0 : tmr_q + 32'h0000_0001;
          if (rx_vld_q) begin
            rcrc_q <= cspc_crc(rcrc_q, rsh_q);
            if (rnum_q < 4'h5) mrx_q[rnum_q[2:0]] <= rsh_q;
            if (rnum_q != 4'hF) rnum_q <= rnum_q + 4'h1;
          end else if (rnum_q != 4'h0 && tmr_q >= gap_cyc) begin
            seq_q    <= S_IDLE;
            mb_ok_q  <= mb_good;
            mb_err_q <= !mb_good;
            if (mb_good && kind_q == K_MBRD)
              reg_read_result_q <= {mrx_q[3], mrx_q[4]};
          end else if (rnum_q == 4'h0 && tmr_q >= RESP_TO_CYC) begin
            seq_q    <= S_IDLE;
            mb_err_q <= 1'b1;
          end
        end
        default: seq_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin controls and read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ser_drv_en    <= 1'b0;
      ser_rcv_en_n  <= 1'b1;
      ser_rs485_sel <= 1'b0;
      ser_edge_fast <= 1'b0;
    end else begin
      ser_drv_en    <= port_enable && (!mode485 || tx_busy_q || out_valid
                       || seq_q == S_SEND);
      ser_rcv_en_n  <= !listen;
      ser_rs485_sel <= mode485;
      ser_edge_fast <= port_enable && mode485 && ctrl_q[CTL_FAST];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) reg_rdata <= '0;
    else if (reg_rd) begin
      reg_rdata <= '0;
      if (reg_addr[7:6] == RGN_RXBUF) reg_rdata[7:0] <= rx_out_q[bidx];
      else if (reg_addr[7:6] == RGN_TXBUF) reg_rdata[7:0] <= text_tx_buffer_q[bidx];
      else
        case (reg_addr)
          OFS_CTRL:   reg_rdata[7:0]  <= ctrl_q;
          OFS_STATUS: begin
            reg_rdata[ST_TXB]          <= seq_q != S_IDLE;
            reg_rdata[ST_FB]           <= fetch_busy_q;
            reg_rdata[ST_MOK]          <= mb_ok_q;
            reg_rdata[ST_MERR]         <= mb_err_q;
            reg_rdata[ST_OVR]          <= overrun_q;
            reg_rdata[ST_LVL+:QW+1]    <= rq_lvl_q;
            reg_rdata[ST_FCNT+:IW+1]   <= fetch_cnt_q;
          end
          OFS_SERVER: reg_rdata[7:0]  <= server_id_q;
          OFS_HADDR:  reg_rdata[15:0] <= holding_reg_addr_q;
          OFS_WVAL:   reg_rdata[15:0] <= reg_write_value_q;
          OFS_RRES:   reg_rdata[15:0] <= reg_read_result_q;
          OFS_TXCNT:  reg_rdata[IW:0] <= raw_tx_count_q;
          OFS_TRXCNT: reg_rdata[IW:0] <= text_rx_count_q;
          OFS_RRXCNT: reg_rdata[IW:0] <= raw_rx_count_q;
          default:    ;
        endcase
    end
  end
endmodule

/* File: core/cspc_pkg.sv */
package cspc_pkg;
  // ----------------------------------------------------------------
  // clock, bus and register map
  // ----------------------------------------------------------------
  localparam int         CLK_HZ     = 200_000_000;
  localparam int         AW         = 8;
  localparam int         DW         = 32;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SERVER = 8'h0C;
  localparam logic [7:0] OFS_HADDR  = 8'h10;
  localparam logic [7:0] OFS_WVAL   = 8'h14;
  localparam logic [7:0] OFS_RRES   = 8'h18;
  localparam logic [7:0] OFS_TXCNT  = 8'h1C;
  localparam logic [7:0] OFS_TRXCNT = 8'h20;
  localparam logic [7:0] OFS_RRXCNT = 8'h24;
  localparam logic [1:0] RGN_TXBUF  = 2'h1;
  localparam logic [1:0] RGN_RXBUF  = 2'h2;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  // control fields
  localparam int CTL_EN   = 0;
  localparam int CTL_MODE = 1;
  localparam int CTL_PROT = 2;
  localparam int CTL_FAST = 4;
  localparam int CTL_BAUD = 5;
  // command bits, write one to fire
  localparam int CMD_TSEND  = 0;
  localparam int CMD_TFETCH = 1;
  localparam int CMD_MBWR   = 2;
  localparam int CMD_MBRD   = 3;
  localparam int CMD_RSEND  = 4;
  localparam int CMD_RFETCH = 5;
  localparam int CMD_CLR    = 6;
  // status fields
  localparam int ST_TXB  = 0;
  localparam int ST_FB   = 1;
  localparam int ST_MOK  = 2;
  localparam int ST_MERR = 3;
  localparam int ST_OVR  = 4;
  localparam int ST_LVL  = 8;
  localparam int ST_FCNT = 16;
  // ----------------------------------------------------------------
  // link framing and protocol constants
  // ----------------------------------------------------------------
  localparam int          BAUD_0     = 9600;
  localparam int          BAUD_1     = 19200;
  localparam int          BAUD_2     = 38400;
  localparam int          BAUD_3     = 57600;
  localparam int          BAUD_4     = 115200;
  localparam int          DATA_BITS  = 8;
  localparam int          GAP_BITS   = 35;
  localparam logic [7:0]  FC_RD      = 8'h03;
  localparam logic [7:0]  FC_WR      = 8'h06;
  localparam logic [15:0] MB_RD_QTY  = 16'h0001;
  localparam logic [15:0] CRC_INIT   = 16'hFFFF;
  localparam logic [15:0] CRC_POLY   = 16'hA001;
  localparam int          MB_CRC_POS = 6;
  localparam int          MB_REQ_LEN = 8;
  localparam int          MB_RD_RLEN = 7;
  localparam int          MB_WR_RLEN = 8;
  localparam int          RESP_TO_MS = 100;
  localparam int          RESP_TO_CYC_DFLT = RESP_TO_MS * (CLK_HZ / 1000);
  typedef enum logic [1:0] {
    PROT_ASCII = 2'b00, PROT_MODBUS = 2'b01, PROT_BINARY = 2'b10
  } cspc_prot_t;
  typedef enum logic [1:0] {
    K_TEXT = 2'b00, K_RAW = 2'b01, K_MBWR = 2'b10, K_MBRD = 2'b11
  } cspc_kind_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_GAP = 3'b001, S_SEND = 3'b010, S_DRAIN = 3'b011, S_WAIT = 3'b100
  } cspc_seq_t;
  function automatic logic [15:0] cspc_div(input logic [2:0] s);
    case (s)
      3'h1:    cspc_div = 16'(CLK_HZ / BAUD_1);
      3'h2:    cspc_div = 16'(CLK_HZ / BAUD_2);
      3'h3:    cspc_div = 16'(CLK_HZ / BAUD_3);
      3'h4:    cspc_div = 16'(CLK_HZ / BAUD_4);
      default: cspc_div = 16'(CLK_HZ / BAUD_0);
    endcase
  endfunction
  function automatic logic [15:0] cspc_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < DATA_BITS; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    cspc_crc = r;
  endfunction
endpackage

/* File: tb/cspc_chk.sv */
`timescale 1ns/1ps
module cspc_chk (
  // clock and bus
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // pins
  input wire logic        ser_txd,
  input wire logic        ser_drv_en,
  input wire logic        ser_rcv_en_n,
  input wire logic        ser_rs485_sel,
  input wire logic        ser_edge_fast
);
  localparam int D = 1736;
  logic [7:0]  c_q, p_q;
  logic [15:0] lo_q, f_q;
  // shadow of the control word, two stages because pin outputs are registered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) {c_q, p_q} <= '0;
    else begin
      if (reg_wr && reg_addr == 8'h00) c_q <= reg_wdata[7:0];
      p_q <= c_q;
    end
  end
  // low-run length and position inside a frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) {lo_q, f_q} <= '0;
    else begin
      lo_q <= ser_txd ? 16'h0000 : lo_q + 16'h0001;
      if (f_q != 0) f_q <= (f_q == 10 * D - 1) ? 16'h0000 : f_q + 16'h0001;
      else if (!ser_txd) f_q <= 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  idle_off_a: assert property (!c_q[0] && !p_q[0] && !$past(p_q[0]) |->
    ser_txd && !ser_drv_en) else $error("link active while disabled");
  full_dup_a: assert property (c_q[1:0] == 2'b01 && p_q[1:0] == 2'b01 |->
    ser_drv_en && !ser_rcv_en_n) else $error("rs232 not full duplex");
  half_dup_a: assert property (p_q[1:0] == 2'b11 && !ser_txd |->
    ser_drv_en && ser_rcv_en_n) else $error("rs485 driver state wrong");
  edge_rate_a: assert property (ser_edge_fast == (p_q[0] & p_q[1] & p_q[4]))
    else $error("edge rate select wrong");
  bit_time_a: assert property ($rose(ser_txd) && c_q[0] |-> lo_q % D == 0)
    else $error("bit time wrong");
  start_bit_a: assert property (f_q == D / 2 && c_q[0] |-> !ser_txd)
    else $error("start bit missing");
  stop_bit_a: assert property (f_q == 9 * D + D / 2 && c_q[0] |-> ser_txd)
    else $error("stop bit missing");
  mb_rs485_a: assert property (c_q[3:2] == 2'b01 && !ser_txd |-> ser_rs485_sel)
    else $error("request sent outside rs485");
  cover property (p_q[1:0] == 2'b11 && !ser_txd);
  cover property ($rose(ser_txd) && c_q[0]);
  cover property (f_q == 9 * D);
endmodule
bind cspc_top cspc_chk i_chk (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .ser_txd,
  .ser_drv_en, .ser_rcv_en_n, .ser_rs485_sel, .ser_edge_fast);

/* File: tb/cspc_dev.sv */
`timescale 1ns/1ps
module cspc_dev #(
  parameter int D = 1736
) (
  // link pins
  input  wire logic clk,
  input  wire logic ser_txd,
  output logic      ser_rxd
);
  logic [7:0] q[$];
  logic [7:0] b;
  // released line idles high; each frame sampled mid-bit, lsb first
  initial begin
    ser_rxd = 1'b1;
    forever begin
      @(negedge ser_txd);
      repeat (D / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (D) @(posedge clk);
        b[i] = ser_txd;
      end
      repeat (D) @(posedge clk);
      if (ser_txd) q.push_back(b);
    end
  end
  // one 8-N-1 character at the shared rate
  task automatic send(input logic [7:0] v);
    for (int i = 0; i < 10; i++) begin
      ser_rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : v[i - 1];
      repeat (D) @(posedge clk);
    end
  endtask
endmodule

/* File: tb/cspc_tb_top.sv */
`timescale 1ns/1ps
module cspc_tb_top;
  import cspc_pkg::*;
  `define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); end end
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ser_rxd, ser_txd;
  logic ser_drv_en, ser_rcv_en_n, ser_rs485_sel, ser_edge_fast;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rv;
  int n_fail = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  cspc_top #(.RESP_TO_CYC(200000)) i_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ser_rxd, .ser_txd, .ser_drv_en, .ser_rcv_en_n, .ser_rs485_sel,
    .ser_edge_fast);
  cspc_dev i_dev (.clk, .ser_txd, .ser_rxd);
  // bus cycle: drive on the edge, taken at the next one
  task automatic bus(input logic w, r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1, 0, a, d);
    bus(0, 0, a, d);
  endtask
  // read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [7:0] a);
    bus(0, 1, a, 32'h0000_0000);
    bus(0, 0, a, 32'h0000_0000);
    @(negedge clk);
    rv = reg_rdata;
  endtask
  task automatic wt;
    for (int i = 0; i < 300; i++) begin
      repeat (100) @(posedge clk);
      rd(OFS_STATUS);
      if (rv[ST_TXB] === 1'b0) break;
    end
  endtask
  task automatic t_raw;
    wr(OFS_CTRL, 32'h0000_0089);
    wr(8'h40, 32'h0000_00A5);
    wr(OFS_TXCNT, 32'h0000_0001);
    wr(OFS_CMD, 32'h0000_0010);
    i_dev.send(8'h5A);
    wt();
    `CK(i_dev.q.size(), 1)
    `CK(i_dev.q[0], 8'hA5)
    wr(OFS_RRXCNT, 32'h0000_0001);
    wr(OFS_CMD, 32'h0000_0020);
    rd(OFS_STATUS);
    `CK(rv[20:16], 5'h01)
    rd(8'h80);
    `CK(rv[7:0], 8'h5A)
    $display("raw test done");
  endtask
  task automatic t_quiet;
    i_dev.q.delete();
    wr(8'h40, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0081);
    wr(OFS_CMD, 32'h0000_0001);
    wt();
    wr(OFS_CTRL, 32'h0000_0088);
    wr(OFS_CMD, 32'h0000_0010);
    repeat (2000) @(posedge clk);
    `CK(i_dev.q.size(), 0)
    `CK(ser_txd, 1'b1)
    $display("quiet test done");
  endtask
  task automatic t_mb;
    wr(OFS_CTRL, 32'h0000_0085);
    wr(OFS_SERVER, 32'h0000_0011);
    wr(OFS_HADDR, 32'h0000_0102);
    wr(OFS_CMD, 32'h0000_0004);
    rd(OFS_STATUS);
    `CK(rv[ST_TXB], 1'b0)
    wr(OFS_CTRL, 32'h0000_0097);
    wr(OFS_CMD, 32'h0000_0004);
    rd(OFS_STATUS);
    `CK(rv[ST_TXB], 1'b1)
    `CK(ser_edge_fast, 1'b1)
    for (int i = 0; i < 90000 && i_dev.q.size() == 0; i++) @(posedge clk);
    `CK(i_dev.q[0], 8'h11)
    wr(OFS_CTRL, 32'h0000_0000);
    repeat (4) @(posedge clk);
    `CK({ser_txd, ser_drv_en}, 2'b10)
    // no reply ever came, so the read result keeps its reset value
    rd(OFS_RRES);
    `CK(rv[15:0], 16'h0000)
    $display("modbus test done");
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog and main sequence
  initial begin
    #600000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_raw();
    t_quiet();
    t_mb();
    final_report();
  end
endmodule
